// >>> hdl/tdf_cfg.svh
// Function
// (R1) Format 00 is 3DW header without data; 01 is 4DW without data.
// (R2) High format bit means payload; low bit picks 3DW or 4DW header.
// (R3) Payloads from 1 to 64 doublewords (4 to 256 bytes) are accepted.
// (R4) Memory and I/O requests route by address against configured windows.
// (R5) Configuration requests route by bus, device and function number.
// (R6) Messages route implicitly, using neither address nor identifier.
// (R7) Message routing subfield type[2:0] selects the message destination.
// (R8) Baseline messages recognised: INTx, PM, error, lock, power, vendor, hotplug.
// (R9) Baseline messages always carry traffic class zero.
// (R10) Advanced-switching messages are not implemented.
// (R11) Isochronous mode is off at reset, on when config bit 26 is set.
// (R12) Control bits choose traffic class 1 to 7 for upstream traffic.
// (R13) Downstream config, I/O and message TLPs with nonzero TC are malformed.
// (R14) Downstream memory TLPs are always forwarded, whatever their class; the code does not forward those with a bad payload length.
// (R15) Payload over 256 bytes or presence mismatching format is malformed.
`ifndef TDF_CFG_SVH
`define TDF_CFG_SVH
`define TDF_FMT_DATA_BIT     1
`define TDF_FMT_4DW_BIT      0
`define TDF_MAX_PAYLOAD_DW   11'h0_040
`define TDF_MSG_TYPE_HI      5'h1_0
`define TDF_CFG0_TYPE        5'h0_4
`define TDF_CFG1_TYPE        5'h0_5
`define TDF_IO_TYPE          5'h0_2
`define TDF_MEM_TYPE         5'h0_0
`define TDF_MEMLK_TYPE       5'h0_1
`define TDF_ISO_EN_BIT       26
`define TDF_TC_ZERO          3'h0
`define TDF_WIN_BITS         3
`define TDF_NUM_WIN          4
`define TDF_MSG_ASI_LO       8'h5_0
`define TDF_MSG_ASI_HI       8'h5_F
`endif

// >>> hdl/tdf_pkg.sv
package tdf_pkg;
  typedef enum logic [1:0] {
    TDF_ROUTE_ADDR,
    TDF_ROUTE_ID,
    TDF_ROUTE_IMPL,
    TDF_ROUTE_NONE
  } tdf_route_type;
  typedef enum logic [3:0] {
    TDF_MSG_NONE,
    TDF_MSG_INTX,
    TDF_MSG_PM,
    TDF_MSG_ERR,
    TDF_MSG_LOCK,
    TDF_MSG_SLOTPWR,
    TDF_MSG_VENDOR,
    TDF_MSG_HOTPLUG,
    TDF_MSG_ASI,
    TDF_MSG_UNKNOWN
  } tdf_msg_type;
endpackage

// >>> hdl/tdf_decode.sv
`timescale 1ns/1ps
`include "tdf_cfg.svh"
`default_nettype none
module tdf_decode
(
  input  wire logic                 clock,
  input  wire logic                 resetn,
  input  wire logic                 hdr_valid,
  input  wire logic [1:0]           hdr_fmt,
  input  wire logic [4:0]           hdr_type,
  input  wire logic [2:0]           hdr_tc,
  input  wire logic [9:0]           hdr_length,
  input  wire logic [7:0]           hdr_msg_code,
  input  wire logic [63:0]          hdr_addr,
  input  wire logic [15:0]          hdr_target_id,
  input  wire logic                 hdr_has_payload,
  input  wire logic [10:0]          payload_dw,
  input  wire logic                 cfg_wr,
  input  wire logic [31:0]          cfg_wdata,
  input  wire logic [2:0]           cfg_up_tc,
  input  wire logic [3:0][63:0]     win_base,
  input  wire logic [3:0][63:0]     win_limit,
  input  wire logic [3:0]           win_enable,
  output logic                      res_valid,
  output logic                      res_hdr_4dw,
  output logic                      res_has_data,
  output logic                      res_malformed,
  output logic                      res_forward,
  output tdf_pkg::tdf_route_type    res_route,
  output logic [3:0]                res_win_hit,
  output logic [15:0]               res_target_id,
  output logic [2:0]                res_msg_dest,
  output tdf_pkg::tdf_msg_type      res_msg_kind,
  output logic                      iso_enable,
  output logic [2:0]                up_tc
);
  logic                   iso_ff;
  logic [2:0]             up_tc_ff;
  logic                   nxt_4dw;
  logic                   nxt_data;
  logic                   is_msg;
  logic                   is_cfg;
  logic                   is_io;
  logic                   is_mem;
  logic                   bad_len;
  logic                   bad_tc;
  logic                   bad_asi;
  logic [3:0]             hit;
  tdf_pkg::tdf_route_type nxt_route;
  tdf_pkg::tdf_msg_type   nxt_kind;
  logic                   valid_ff;
  logic                   hdr4_ff;
  logic                   data_ff;
  logic                   mal_ff;
  logic                   fwd_ff;
  tdf_pkg::tdf_route_type route_ff;
  logic [3:0]             hit_ff;
  logic [15:0]            tid_ff;
  logic [2:0]             dest_ff;
  tdf_pkg::tdf_msg_type   kind_ff;

  assign nxt_data = hdr_fmt[`TDF_FMT_DATA_BIT];  // [R1] [R2]
  assign nxt_4dw  = hdr_fmt[`TDF_FMT_4DW_BIT];   // [R1] [R2]
  assign is_msg = hdr_type[4:3] == 2'(`TDF_MSG_TYPE_HI >> 3);
  assign is_cfg = hdr_type == `TDF_CFG0_TYPE || hdr_type == `TDF_CFG1_TYPE;
  assign is_io  = hdr_type == `TDF_IO_TYPE;
  assign is_mem = hdr_type == `TDF_MEM_TYPE || hdr_type == `TDF_MEMLK_TYPE;

  // Zero length field encodes 1024 DW, so caller gives explicit count
  assign bad_len = (nxt_data != hdr_has_payload) ||
                   (nxt_data && (payload_dw == 11'h0_000 ||
                    payload_dw > `TDF_MAX_PAYLOAD_DW));  // [R3] [R15]
  assign bad_tc = (is_cfg || is_io || is_msg) &&
                  hdr_tc != `TDF_TC_ZERO;  // [R9] [R13]
  assign bad_asi = is_msg && nxt_kind == tdf_pkg::TDF_MSG_ASI;  // [R10]

  genvar gi;
  generate
    for (gi = 0; gi < `TDF_NUM_WIN; gi++)
    begin : g_win
      assign hit[gi] = win_enable[gi] && hdr_addr >= win_base[gi] &&
                       hdr_addr <= win_limit[gi];  // [R4]
    end
  endgenerate

  always_comb
  begin
    nxt_route = tdf_pkg::TDF_ROUTE_NONE;
    if (is_mem || is_io)
      nxt_route = tdf_pkg::TDF_ROUTE_ADDR;  // [R4]
    else if (is_cfg)
      nxt_route = tdf_pkg::TDF_ROUTE_ID;    // [R5]
    else if (is_msg)
      nxt_route = tdf_pkg::TDF_ROUTE_IMPL;  // [R6]
  end

  always_comb
  begin
    nxt_kind = tdf_pkg::TDF_MSG_NONE;
    if (is_msg)
    begin
      unique casez (hdr_msg_code)  // [R8]
        8'b0010_0???: nxt_kind = tdf_pkg::TDF_MSG_INTX;
        8'b0001_????: nxt_kind = tdf_pkg::TDF_MSG_PM;
        8'b0011_0???: nxt_kind = tdf_pkg::TDF_MSG_ERR;
        8'b0000_0000: nxt_kind = tdf_pkg::TDF_MSG_LOCK;
        8'b0101_0000: nxt_kind = tdf_pkg::TDF_MSG_SLOTPWR;
        8'b0111_111?: nxt_kind = tdf_pkg::TDF_MSG_VENDOR;
        8'b0100_????: nxt_kind = tdf_pkg::TDF_MSG_HOTPLUG;
        default:
          if (hdr_msg_code > `TDF_MSG_ASI_LO &&
              hdr_msg_code <= `TDF_MSG_ASI_HI)
            nxt_kind = tdf_pkg::TDF_MSG_ASI;  // [R10]
          else
            nxt_kind = tdf_pkg::TDF_MSG_UNKNOWN;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
      iso_ff <= 1'b0;  // [R11]
    else if (cfg_wr)
      iso_ff <= cfg_wdata[`TDF_ISO_EN_BIT];  // [R11]
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
      up_tc_ff <= `TDF_TC_ZERO;
    else if (!iso_ff)
      up_tc_ff <= `TDF_TC_ZERO;
    else if (cfg_up_tc != `TDF_TC_ZERO)
      up_tc_ff <= cfg_up_tc;  // [R12]
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      valid_ff <= 1'b0;
      hdr4_ff  <= 1'b0;
      data_ff  <= 1'b0;
      mal_ff   <= 1'b0;
      fwd_ff   <= 1'b0;
      route_ff <= tdf_pkg::TDF_ROUTE_NONE;
      hit_ff   <= 4'h0;
      tid_ff   <= 16'h0000;
      dest_ff  <= 3'h0;
      kind_ff  <= tdf_pkg::TDF_MSG_NONE;
    end
    else
    begin
      valid_ff <= hdr_valid;
      if (hdr_valid)
      begin
        hdr4_ff  <= nxt_4dw;
        data_ff  <= nxt_data;
        mal_ff   <= bad_len || bad_tc || bad_asi;  // [R13] [R15]
        // Memory forwards regardless of TC or iso mode
        fwd_ff   <= !(bad_len || bad_tc || bad_asi) &&
                    (is_mem || is_io || is_cfg || is_msg);  // [R14]
        route_ff <= nxt_route;
        hit_ff   <= (is_mem || is_io) ? hit : 4'h0;  // [R4]
        tid_ff   <= is_cfg ? hdr_target_id : 16'h0000;  // [R5]
        dest_ff  <= is_msg ? hdr_type[2:0] : 3'h0;  // [R7]
        kind_ff  <= nxt_kind;
      end
    end
  end

  assign res_valid     = valid_ff;
  assign res_hdr_4dw   = hdr4_ff;
  assign res_has_data  = data_ff;
  assign res_malformed = mal_ff;
  assign res_forward   = fwd_ff;
  assign res_route     = route_ff;
  assign res_win_hit   = hit_ff;
  assign res_target_id = tid_ff;
  assign res_msg_dest  = dest_ff;
  assign res_msg_kind  = kind_ff;
  assign iso_enable    = iso_ff;
  assign up_tc         = up_tc_ff;

  chk_fmt_data: assert property (  // [R2]
    @(posedge clock) disable iff (!resetn)
    hdr_valid |=> res_has_data == $past(hdr_fmt[1]))
    else $error("data flag wrong");
  chk_fmt_hdr: assert property (  // [R1]
    @(posedge clock) disable iff (!resetn)
    hdr_valid |=> res_hdr_4dw == $past(hdr_fmt[0]))
    else $error("header size wrong");
  chk_tc_bad: assert property (  // [R13]
    @(posedge clock) disable iff (!resetn)
    hdr_valid && (is_cfg || is_io || is_msg) && hdr_tc != 3'h0
    |=> res_malformed && !res_forward)
    else $error("nonzero TC not malformed");
  chk_mem_fwd: assert property (  // [R14]
    @(posedge clock) disable iff (!resetn)
    hdr_valid && is_mem && !bad_len |=> res_forward)
    else $error("memory not forwarded");
  chk_len_big: assert property (  // [R15]
    @(posedge clock) disable iff (!resetn)
    hdr_valid && hdr_fmt[1] && payload_dw > `TDF_MAX_PAYLOAD_DW
    |=> res_malformed)
    else $error("oversize payload accepted");
  chk_len_ok: assert property (  // [R3]
    @(posedge clock) disable iff (!resetn)
    hdr_valid && is_mem && hdr_fmt[1] && hdr_has_payload &&
    payload_dw >= 11'h0_001 && payload_dw <= `TDF_MAX_PAYLOAD_DW
    |=> !res_malformed)
    else $error("legal payload rejected");
  chk_cfg_route: assert property (  // [R5]
    @(posedge clock) disable iff (!resetn)
    hdr_valid && is_cfg |=> res_route == tdf_pkg::TDF_ROUTE_ID &&
    res_target_id == $past(hdr_target_id))
    else $error("config not ID routed");
  chk_msg_route: assert property (  // [R6] [R7]
    @(posedge clock) disable iff (!resetn)
    hdr_valid && is_msg |=> res_route == tdf_pkg::TDF_ROUTE_IMPL &&
    res_msg_dest == $past(hdr_type[2:0]))
    else $error("message routing wrong");
  chk_iso_off: assert property (  // [R11]
    @(posedge clock)
    !resetn |=> !iso_enable && up_tc == 3'h0)
    else $error("iso not off after reset");
  chk_asi_bad: assert property (  // [R10]
    @(posedge clock) disable iff (!resetn)
    hdr_valid && is_msg && hdr_msg_code > `TDF_MSG_ASI_LO &&
    hdr_msg_code <= `TDF_MSG_ASI_HI |=> res_malformed && !res_forward)
    else $error("switching message accepted");
  chk_tc_sel: assert property (  // [R12]
    @(posedge clock) disable iff (!resetn)
    iso_enable && cfg_up_tc != 3'h0 |=> up_tc == $past(cfg_up_tc))
    else $error("upstream class not taken");
  chk_tc_idle: assert property (  // [R11]
    @(posedge clock) disable iff (!resetn)
    !iso_enable |=> up_tc == 3'h0)
    else $error("upstream class set while iso off");
endmodule
`default_nettype wire

// >>> tb/tdf_link_partner.sv
`timescale 1ns/1ps
`default_nettype none
// Stands for the upstream link partner sending header fields
module tdf_link_partner
(
  input  wire logic        clock,
  output logic             hdr_valid,
  output logic [1:0]       hdr_fmt,
  output logic [4:0]       hdr_type,
  output logic [2:0]       hdr_tc,
  output logic [7:0]       hdr_msg_code,
  output logic [63:0]      hdr_addr,
  output logic [15:0]      hdr_target_id,
  output logic             hdr_has_payload,
  output logic [10:0]      payload_dw
);
  initial
  begin
    hdr_valid = 1'h0;
    {hdr_fmt, hdr_type, hdr_tc, hdr_msg_code} = 18'h0_0000;
    {hdr_addr, hdr_target_id, hdr_has_payload, payload_dw} = 92'h0;
  end
  task automatic send(input logic [1:0] f, input logic [4:0] t,
    input logic [2:0] c, input logic [7:0] m, input logic [63:0] a,
    input logic [15:0] i, input logic p, input logic [10:0] d);
    @(posedge clock);
    hdr_valid <= 1'h1;
    {hdr_fmt, hdr_type, hdr_tc} <= {f, t, c};
    {hdr_msg_code, hdr_addr, hdr_target_id} <= {m, a, i};
    {hdr_has_payload, payload_dw} <= {p, d};
    @(posedge clock);
    hdr_valid <= 1'h0;
    // Idle fields flip so a stale header can never look valid
    {hdr_fmt, hdr_type, hdr_tc, hdr_msg_code} <=
      ~{hdr_fmt, hdr_type, hdr_tc, hdr_msg_code};
    {hdr_addr, hdr_target_id, hdr_has_payload, payload_dw} <=
      ~{hdr_addr, hdr_target_id, hdr_has_payload, payload_dw};
  endtask
endmodule
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic                   clock = 1'h0;
  logic                   resetn = 1'h0;
  logic                   cfg_wr = 1'h0;
  logic [31:0]            cfg_wdata = 32'h0000_0000;
  logic [2:0]             cfg_up_tc = 3'h0;
  logic [3:0][63:0]       win_base = {64'h0, 64'h0, 64'h2000, 64'h1000};
  logic [3:0][63:0]       win_limit = {{2{64'hFFFF}}, 64'h2FFF, 64'h1FFF};
  logic [3:0]             win_enable = 4'h3;
  logic                   hdr_valid, hdr_has_payload, res_valid;
  logic                   res_hdr_4dw, res_has_data, res_malformed;
  logic                   res_forward, iso_enable;
  logic [1:0]             hdr_fmt;
  logic [4:0]             hdr_type;
  logic [2:0]             hdr_tc, res_msg_dest, up_tc;
  logic [7:0]             hdr_msg_code;
  logic [63:0]            hdr_addr;
  logic [15:0]            hdr_target_id, res_target_id;
  logic [10:0]            payload_dw;
  logic [3:0]             res_win_hit;
  tdf_pkg::tdf_route_type res_route;
  tdf_pkg::tdf_msg_type   res_msg_kind;
  int                     n_mismatch = 0;
  int                     n_checks = 0;

  always #2 clock = ~clock;

  tdf_link_partner partner (.clock(clock), .hdr_valid(hdr_valid),
    .hdr_fmt(hdr_fmt), .hdr_type(hdr_type), .hdr_tc(hdr_tc),
    .hdr_msg_code(hdr_msg_code), .hdr_addr(hdr_addr),
    .hdr_target_id(hdr_target_id), .hdr_has_payload(hdr_has_payload),
    .payload_dw(payload_dw));

  tdf_decode DUT (.clock(clock), .resetn(resetn), .hdr_valid(hdr_valid),
    .hdr_fmt(hdr_fmt), .hdr_type(hdr_type), .hdr_tc(hdr_tc),
    .hdr_length(10'h000), .hdr_msg_code(hdr_msg_code),
    .hdr_addr(hdr_addr), .hdr_target_id(hdr_target_id),
    .hdr_has_payload(hdr_has_payload), .payload_dw(payload_dw),
    .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .cfg_up_tc(cfg_up_tc),
    .win_base(win_base), .win_limit(win_limit), .win_enable(win_enable),
    .res_valid(res_valid), .res_hdr_4dw(res_hdr_4dw),
    .res_has_data(res_has_data), .res_malformed(res_malformed),
    .res_forward(res_forward), .res_route(res_route),
    .res_win_hit(res_win_hit), .res_target_id(res_target_id),
    .res_msg_dest(res_msg_dest), .res_msg_kind(res_msg_kind),
    .iso_enable(iso_enable), .up_tc(up_tc));

  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] e,
    input logic [15:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  // Sends one header and waits, bounded, for its one-cycle result
  task automatic pkt(input logic [1:0] f, input logic [4:0] t,
    input logic [2:0] c, input logic [7:0] m, input logic [63:0] a,
    input logic [15:0] i, input logic p, input logic [10:0] d);
    int k;
    k = 0;
    partner.send(f, t, c, m, a, i, p, d);
    #1;
    while (res_valid !== 1'h1 && k < 4)
    begin
      @(posedge clock);
      #1;
      k++;
    end
    if (res_valid !== 1'h1)
    begin
      n_mismatch++;
      results;
    end
  endtask

  task automatic t_mem;
    pkt(2'h2, 5'h00, 3'h5, 8'h00, 64'h1800, 16'h0, 1'h1, 11'h010);
    chk("forward", 16'h1, 16'(res_forward));
    chk("route", 16'(tdf_pkg::TDF_ROUTE_ADDR), 16'(res_route));
    chk("data", 16'h1, 16'(res_has_data));
    chk("hdr4", 16'h0, 16'(res_hdr_4dw));
    chk("win", 16'h1, 16'(res_win_hit));
    pkt(2'h3, 5'h00, 3'h0, 8'h00, 64'h2FFF, 16'h0, 1'h1, 11'h040);
    chk("hdr4", 16'h1, 16'(res_hdr_4dw));
    chk("win", 16'h2, 16'(res_win_hit));
    chk("bad", 16'h0, 16'(res_malformed));
    pkt(2'h3, 5'h00, 3'h0, 8'h00, 64'h1000, 16'h0, 1'h1, 11'h041);
    chk("bad", 16'h1, 16'(res_malformed));
    chk("forward", 16'h0, 16'(res_forward));
    pkt(2'h2, 5'h00, 3'h0, 8'h00, 64'h1000, 16'h0, 1'h0, 11'h000);
    chk("bad", 16'h1, 16'(res_malformed));
    $display("test mem done");
  endtask

  task automatic t_cfg;
    pkt(2'h0, 5'h04, 3'h0, 8'h00, 64'h0, 16'h1234, 1'h0, 11'h000);
    chk("route", 16'(tdf_pkg::TDF_ROUTE_ID), 16'(res_route));
    chk("id", 16'h1234, res_target_id);
    chk("data", 16'h0, 16'(res_has_data));
    chk("bad", 16'h0, 16'(res_malformed));
    pkt(2'h0, 5'h05, 3'h2, 8'h00, 64'h0, 16'h0042, 1'h0, 11'h000);
    chk("bad", 16'h1, 16'(res_malformed));
    pkt(2'h0, 5'h02, 3'h7, 8'h00, 64'h1000, 16'h0, 1'h0, 11'h000);
    chk("bad", 16'h1, 16'(res_malformed));
    pkt(2'h0, 5'h0A, 3'h0, 8'h00, 64'h1000, 16'h0, 1'h0, 11'h000);
    chk("route", 16'(tdf_pkg::TDF_ROUTE_NONE), 16'(res_route));
    chk("forward", 16'h0, 16'(res_forward));
    chk("bad", 16'h0, 16'(res_malformed));
    $display("test cfg done");
  endtask

  task automatic t_msg;
    pkt(2'h1, 5'h14, 3'h0, 8'h20, 64'h0, 16'h0, 1'h0, 11'h000);
    chk("route", 16'(tdf_pkg::TDF_ROUTE_IMPL), 16'(res_route));
    chk("dest", 16'h4, 16'(res_msg_dest));
    chk("kind", 16'(tdf_pkg::TDF_MSG_INTX), 16'(res_msg_kind));
    chk("hdr4", 16'h1, 16'(res_hdr_4dw));
    pkt(2'h1, 5'h14, 3'h3, 8'h20, 64'h0, 16'h0, 1'h0, 11'h000);
    chk("bad", 16'h1, 16'(res_malformed));
    pkt(2'h1, 5'h13, 3'h0, 8'h52, 64'h0, 16'h0, 1'h0, 11'h000);
    chk("bad", 16'h1, 16'(res_malformed));
    pkt(2'h1, 5'h10, 3'h0, 8'h18, 64'h0, 16'h0, 1'h0, 11'h000);
    chk("kind", 16'(tdf_pkg::TDF_MSG_PM), 16'(res_msg_kind));
    chk("dest", 16'h0, 16'(res_msg_dest));
    pkt(2'h1, 5'h10, 3'h0, 8'h30, 64'h0, 16'h0, 1'h0, 11'h000);
    chk("kind", 16'(tdf_pkg::TDF_MSG_ERR), 16'(res_msg_kind));
    pkt(2'h1, 5'h13, 3'h0, 8'h00, 64'h0, 16'h0, 1'h0, 11'h000);
    chk("kind", 16'(tdf_pkg::TDF_MSG_LOCK), 16'(res_msg_kind));
    chk("dest", 16'h3, 16'(res_msg_dest));
    pkt(2'h1, 5'h14, 3'h0, 8'h50, 64'h0, 16'h0, 1'h0, 11'h000);
    chk("kind", 16'(tdf_pkg::TDF_MSG_SLOTPWR), 16'(res_msg_kind));
    pkt(2'h1, 5'h14, 3'h0, 8'h7E, 64'h0, 16'h0, 1'h0, 11'h000);
    chk("kind", 16'(tdf_pkg::TDF_MSG_VENDOR), 16'(res_msg_kind));
    pkt(2'h1, 5'h14, 3'h0, 8'h40, 64'h0, 16'h0, 1'h0, 11'h000);
    chk("kind", 16'(tdf_pkg::TDF_MSG_HOTPLUG), 16'(res_msg_kind));
    chk("forward", 16'h1, 16'(res_forward));
    pkt(2'h1, 5'h14, 3'h0, 8'h60, 64'h0, 16'h0, 1'h0, 11'h000);
    chk("kind", 16'(tdf_pkg::TDF_MSG_UNKNOWN), 16'(res_msg_kind));
    chk("bad", 16'h0, 16'(res_malformed));
    $display("test msg done");
  endtask

  task automatic t_iso;
    #1;
    chk("iso", 16'h0, 16'(iso_enable));
    chk("uptc", 16'h0, 16'(up_tc));
    @(posedge clock);
    cfg_up_tc <= 3'h3;
    cfg_wr <= 1'h1;
    cfg_wdata <= 32'h0400_0000;
    @(posedge clock);
    cfg_wr <= 1'h0;
    #1;
    chk("iso", 16'h1, 16'(iso_enable));
    @(posedge clock);
    #1;
    chk("uptc", 16'h3, 16'(up_tc));
    pkt(2'h2, 5'h00, 3'h7, 8'h00, 64'h1004, 16'h0, 1'h1, 11'h001);
    chk("forward", 16'h1, 16'(res_forward));
    $display("test iso done");
  endtask

  // Mid-run reset must drop iso mode even with a class still requested
  task automatic t_rst;
    @(posedge clock);
    resetn <= 1'h0;
    repeat (2) @(posedge clock);
    resetn <= 1'h1;
    #1;
    chk("iso", 16'h0, 16'(iso_enable));
    chk("uptc", 16'h0, 16'(up_tc));
    chk("valid", 16'h0, 16'(res_valid));
    chk("route", 16'(tdf_pkg::TDF_ROUTE_NONE), 16'(res_route));
    $display("test reset done");
  endtask

  initial
  begin
    repeat (5) @(posedge clock);
    #1;
    chk("valid", 16'h0, 16'(res_valid));
    chk("route", 16'(tdf_pkg::TDF_ROUTE_NONE), 16'(res_route));
    @(posedge clock);
    resetn <= 1'h1;
    t_iso;
    t_rst;
    t_mem;
    t_cfg;
    t_msg;
    results;
  end
endmodule
`default_nettype wire
